//--- core/sldiag_top.sv
/*
  sldiag_top: front-panel two-colour status indicator plus eight-bit
  progress code display.
  The indicator picks the most severe reported condition and drives the
  amber and green dies from registers; the display mirrors the last code.
  Assumes condition inputs are synchronous to clk and that firmware
  pulses code_wr_en for one cycle per code.
  Assumes both indicator dies and all eight display bits light when high.
*/
`timescale 1ns/1ps

module sldiag_top #(
  parameter longint unsigned BLINK_HALF = sldiag_pkg::BLINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mains_present,
  input wire logic thermal_trip,
  input wire logic nonrec_temp,
  input wire logic nonrec_voltage,
  input wire logic power_fault,
  input wire logic uncorrectable_mem,
  input wire logic fan_redundant_cfg,
  input wire logic fan_redund_lost,
  input wire logic cooling_sufficient,
  input wire logic catastrophic_error,
  input wire logic crit_temp,
  input wire logic crit_voltage,
  input wire logic crit_fan,
  input wire logic regulator_hot,
  input wire logic mgmt_interrupt_timeout,
  input wire logic dimm_err_threshold,
  input wire logic noncrit_temp,
  input wire logic noncrit_voltage,
  input wire logic noncrit_fan,
  input wire logic psu_predictive_fail,
  input wire logic channel_err_threshold,
  input wire logic mem_unusable,
  input wire logic multi_dimm_installed,
  input wire logic system_ready,
  input wire logic code_wr_en,
  input wire logic [sldiag_pkg::CODE_W-1:0] code_wr_data,
  output logic led_amber,
  output logic led_green,
  output logic [sldiag_pkg::CODE_W-1:0] post_indicator
);
  import sldiag_pkg::*;

  localparam logic [31:0] HALF_M1 = 32'(BLINK_HALF - 1);

  logic fatal;
  logic alarm;
  logic degraded;
  logic redund_active;
  logic redund_fatal;
  logic redund_degr;
  logic mem_degr;
  sldiag_state_e state_d;
  sldiag_state_e state_q;
  logic [31:0] div_q;
  logic blink_q;
  logic [CODE_W-1:0] code_q;

  // redundancy inputs mean nothing on non-redundant builds
  assign redund_active = fan_redundant_cfg & fan_redund_lost;
  assign redund_fatal = redund_active & ~cooling_sufficient;
  assign redund_degr = redund_active & cooling_sufficient;
  // a single module cannot leave memory unused in a degraded sense
  assign mem_degr = mem_unusable & multi_dimm_installed;

  // fatal group: the system has failed or shut down
  assign fatal = thermal_trip
                 | nonrec_temp
                 | nonrec_voltage
                 | power_fault
                 | uncorrectable_mem
                 | redund_fatal;

  // non-fatal alarm group: failure is likely
  assign alarm = catastrophic_error
                 | crit_temp
                 | crit_voltage
                 | crit_fan
                 | regulator_hot
                 | mgmt_interrupt_timeout
                 | dimm_err_threshold;

  // degraded group: running on reduced margin
  assign degraded = noncrit_temp
                    | noncrit_voltage
                    | noncrit_fan
                    | redund_degr
                    | psu_predictive_fail
                    | channel_err_threshold
                    | mem_degr;

  // severity priority; conditions reported without mains still light the panel
  always_comb begin
    if (fatal) begin
      state_d = SLDIAG_AMBER_ON;
    end else if (alarm) begin
      state_d = SLDIAG_AMBER_BLK;
    end else if (degraded) begin
      state_d = SLDIAG_GREEN_BLK;
    end else if (mains_present && system_ready) begin
      state_d = SLDIAG_GREEN_ON;
    end else begin
      state_d = SLDIAG_OFF;
    end
  end

  // registered state keeps the outputs glitch free
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SLDIAG_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // severity selection checks, one edge after the inputs are sampled
  chk_fatal_state: assert property (@(posedge clk) disable iff (!reset_n)
    fatal |=> state_q == SLDIAG_AMBER_ON)
    else $error("fatal condition did not select steady amber");
  chk_redund_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    (!fan_redundant_cfg && fan_redund_lost && !cooling_sufficient && !thermal_trip && !nonrec_temp
     && !nonrec_voltage && !power_fault && !uncorrectable_mem) |=> state_q != SLDIAG_AMBER_ON)
    else $error("redundancy input honoured on non-redundant system");
  chk_alarm_state: assert property (@(posedge clk) disable iff (!reset_n)
    (alarm && !fatal) |=> state_q == SLDIAG_AMBER_BLK)
    else $error("alarm did not select blinking amber");
  chk_degr_state: assert property (@(posedge clk) disable iff (!reset_n)
    (degraded && !fatal && !alarm) |=> state_q == SLDIAG_GREEN_BLK)
    else $error("degraded condition did not blink green");
  chk_redund_degr: assert property (@(posedge clk) disable iff (!reset_n)
    (fan_redundant_cfg && fan_redund_lost && cooling_sufficient && !fatal && !alarm) |=> state_q == SLDIAG_GREEN_BLK)
    else $error("cooled redundancy loss did not blink green");
  chk_mem_multi: assert property (@(posedge clk) disable iff (!reset_n)
    (mem_unusable && multi_dimm_installed && !fatal && !alarm) |=> state_q == SLDIAG_GREEN_BLK)
    else $error("unusable memory with several modules did not blink green");
  chk_mem_single: assert property (@(posedge clk) disable iff (!reset_n)
    (mem_unusable && !multi_dimm_installed && !fatal && !alarm && !noncrit_temp && !noncrit_voltage
     && !noncrit_fan && !redund_active && !psu_predictive_fail && !channel_err_threshold) |=> state_q != SLDIAG_GREEN_BLK)
    else $error("memory degradation flagged with one module");
  chk_unready_off: assert property (@(posedge clk) disable iff (!reset_n)
    (!system_ready && !fatal && !alarm && !degraded) |=> state_q == SLDIAG_OFF)
    else $error("unready system left the indicator lit");
  chk_degr_over_ok: assert property (@(posedge clk) disable iff (!reset_n)
    (degraded && !fatal && !alarm && mains_present && system_ready) |=> state_q == SLDIAG_GREEN_BLK)
    else $error("ready state hid a degraded condition");
  chk_alarm_over_degr: assert property (@(posedge clk) disable iff (!reset_n)
    (alarm && degraded && !fatal) |=> state_q == SLDIAG_AMBER_BLK)
    else $error("degraded condition hid an alarm");
  chk_prio_order: assert property (@(posedge clk) disable iff (!reset_n)
    (fatal && alarm && degraded) |=> state_q == SLDIAG_AMBER_ON)
    else $error("severity priority not kept");
  chk_onehot_state: assert property (@(posedge clk) disable iff (!reset_n)
    $onehot(state_q))
    else $error("indicator state lost its one-hot code");

  // free-running divider; blink phase shared by both colours
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 32'h0;
      blink_q <= 1'b0;
    end else if (div_q >= HALF_M1) begin
      div_q <= 32'h0;
      blink_q <= ~blink_q;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // divider checks; the >= compare also wraps a counter knocked past the end
  chk_blink_rate: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(blink_q) |-> $past(div_q) == HALF_M1)
    else $error("blink toggled off the divider period");
  chk_div_range: assert property (@(posedge clk) disable iff (!reset_n)
    div_q <= HALF_M1)
    else $error("blink divider ran past its end");
  chk_blink_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (div_q != HALF_M1) |=> $stable(blink_q))
    else $error("blink phase moved mid period");

  // colour drive from the state and the blink phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      led_amber <= 1'b0;
      led_green <= 1'b0;
    end else begin
      unique case (state_q)
        SLDIAG_OFF: begin
          led_amber <= 1'b0;
          led_green <= 1'b0;
        end
        SLDIAG_AMBER_ON: begin
          led_amber <= 1'b1;
          led_green <= 1'b0;
        end
        SLDIAG_AMBER_BLK: begin
          led_amber <= blink_q;
          led_green <= 1'b0;
        end
        SLDIAG_GREEN_BLK: begin
          led_amber <= 1'b0;
          led_green <= blink_q;
        end
        SLDIAG_GREEN_ON: begin
          led_amber <= 1'b0;
          led_green <= 1'b1;
        end
        default: begin
          led_amber <= 1'b0;
          led_green <= 1'b0;
        end
      endcase
    end
  end

  // colour checks: inputs reach the dies two edges after they are sampled
  chk_fatal_amber: assert property (@(posedge clk) disable iff (!reset_n)
    fatal |-> ##2 (led_amber && !led_green))
    else $error("fatal condition did not give steady amber");
  chk_redund_fatal: assert property (@(posedge clk) disable iff (!reset_n)
    (fan_redundant_cfg && fan_redund_lost && !cooling_sufficient) |-> ##2 (led_amber && !led_green))
    else $error("uncooled redundancy loss did not give steady amber");
  chk_alarm_amber: assert property (@(posedge clk) disable iff (!reset_n)
    (alarm && !fatal) |-> ##2 !led_green)
    else $error("alarm lit the green die");
  chk_green_ready: assert property (@(posedge clk) disable iff (!reset_n)
    (mains_present && system_ready && !fatal && !alarm && !degraded) |-> ##2 (led_green && !led_amber))
    else $error("ready system not steady green");
  chk_degr_no_amber: assert property (@(posedge clk) disable iff (!reset_n)
    (degraded && !fatal && !alarm) |-> ##2 !led_amber)
    else $error("degraded condition lit the amber die");
  chk_dark_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (!mains_present && !fatal && !alarm && !degraded) |-> ##2 (!led_amber && !led_green))
    else $error("indicator lit while idle without mains");
  chk_off_led: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == SLDIAG_OFF |=> (!led_amber && !led_green))
    else $error("off state lit a die");
  chk_steady_amber_led: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == SLDIAG_AMBER_ON |=> (led_amber && !led_green))
    else $error("steady amber state not shown");
  chk_steady_green_led: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == SLDIAG_GREEN_ON |=> (led_green && !led_amber))
    else $error("steady green state not shown");
  chk_amber_blink_led: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == SLDIAG_AMBER_BLK |=> (led_amber == $past(blink_q) && !led_green))
    else $error("amber die not following the blink phase");
  chk_green_blink_led: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == SLDIAG_GREEN_BLK |=> (led_green == $past(blink_q) && !led_amber))
    else $error("green die not following the blink phase");

  // progress code latch; held across a hang until the next write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= CODE_RST;
    end else if (code_wr_en) begin
      code_q <= code_wr_data;
    end
  end

  // bit seven drives the top indicator, bit zero the bottom one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      post_indicator <= CODE_RST;
    end else begin
      post_indicator <= code_q;
    end
  end

  // progress code checks; a code lands on the display two edges after its write
  chk_code_show: assert property (@(posedge clk) disable iff (!reset_n)
    code_wr_en |-> ##2 post_indicator == $past(code_wr_data, 2))
    else $error("written code not displayed");
  chk_code_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !code_wr_en |=> code_q == $past(code_q))
    else $error("progress code changed without a write");
  chk_post_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (!code_wr_en && !$past(code_wr_en)) |=> $stable(post_indicator))
    else $error("display moved without a write");
  chk_bit_order: assert property (@(posedge clk) disable iff (!reset_n)
    post_indicator[7] == $past(code_q[7]) && post_indicator[0] == $past(code_q[0]))
    else $error("indicator bit order wrong");
  chk_code_mirror: assert property (@(posedge clk) disable iff (!reset_n)
    post_indicator == $past(code_q))
    else $error("display does not mirror the latched code");

  // main scenarios worth seeing at least once
  cov_amber_blink: cover property (@(posedge clk) disable iff (!reset_n) state_q == SLDIAG_AMBER_BLK && $changed(blink_q));
  cov_green_blink: cover property (@(posedge clk) disable iff (!reset_n) state_q == SLDIAG_GREEN_BLK && $changed(blink_q));
  cov_fatal_over: cover property (@(posedge clk) disable iff (!reset_n) fatal && alarm);
  cov_code_write: cover property (@(posedge clk) disable iff (!reset_n) code_wr_en ##1 code_wr_en);
  cov_mem_degr: cover property (@(posedge clk) disable iff (!reset_n) state_q == SLDIAG_GREEN_BLK && mem_degr);
endmodule

//--- core/sldiag_pkg.sv
/*
  sldiag_pkg: shared constants and types for the status indicator and
  progress code display block.
  Assumes a single 250 MHz system clock; sldiag_top and the bench files import it.
*/
package sldiag_pkg;
  // clock rate and blink timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam longint unsigned BLINK_HALF_CYC = (longint'(BLINK_HALF_MS) * 1000000000) / CLK_PERIOD_PS;
  localparam int unsigned CODE_W = 8;
  localparam logic [7:0] CODE_RST = 8'h00;

  // indicator states, one-hot
  typedef enum logic [4:0] {
    SLDIAG_OFF       = 5'b00001,
    SLDIAG_AMBER_ON  = 5'b00010,
    SLDIAG_AMBER_BLK = 5'b00100,
    SLDIAG_GREEN_BLK = 5'b01000,
    SLDIAG_GREEN_ON  = 5'b10000
  } sldiag_state_e;
endpackage

//--- bench/sldiag_host_model.sv
/*
  sldiag_host_model: stands in for boot firmware and the management
  controller, driving condition levels and progress code writes.
  Assumes callers enter its tasks 1 ns after a rising edge of clk.
*/
`timescale 1ns/1ps
module sldiag_host_model (
  input wire logic clk,
  output logic [23:0] cond,
  output logic code_wr_en,
  output logic [sldiag_pkg::CODE_W-1:0] code_wr_data
);
  import sldiag_pkg::*;
  // all conditions clear and no write pending from time zero
  initial begin
    cond = 24'h000000;
    code_wr_en = 1'b0;
    code_wr_data = 8'h00;
  end
  // levels are held until the next call
  task automatic set_cond(input logic [23:0] c);
    cond = c;
  endtask
  // one code per routine start; strobe left up so codes can go back to back
  task automatic write_code(input logic [CODE_W-1:0] c);
    code_wr_en = 1'b1;
    code_wr_data = c;
    @(posedge clk) #1;
  endtask
  // data bus flips once released so a stale code is never mistaken for a write
  task automatic idle();
    code_wr_en = 1'b0;
    code_wr_data = ~code_wr_data;
    @(posedge clk) #1;
  endtask
endmodule

//--- bench/testbench.sv
/*
  testbench: drives sldiag_top through the host model and checks the
  status colours and the progress code display.
  Assumes the design answers two edges after a sampled input.
*/
`timescale 1ns/1ps
module testbench;
  import sldiag_pkg::*;
  localparam logic [23:0] BASE = 24'h800001; // mains and ready set
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [23:0] cond;
  logic code_wr_en;
  logic [CODE_W-1:0] code_wr_data;
  logic led_amber;
  logic led_green;
  logic [CODE_W-1:0] post_indicator;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  sldiag_host_model sldiag_host_model_inst (.clk(clk), .cond(cond), .code_wr_en(code_wr_en),
    .code_wr_data(code_wr_data));
  // short blink half period keeps the run brief
  sldiag_top #(.BLINK_HALF(4)) sldiag_top_inst (.clk(clk), .reset_n(reset_n),
    .mains_present(cond[0]), .thermal_trip(cond[1]), .nonrec_temp(cond[2]),
    .nonrec_voltage(cond[3]), .power_fault(cond[4]), .uncorrectable_mem(cond[5]),
    .fan_redundant_cfg(cond[6]), .fan_redund_lost(cond[7]), .cooling_sufficient(cond[8]),
    .catastrophic_error(cond[9]), .crit_temp(cond[10]), .crit_voltage(cond[11]),
    .crit_fan(cond[12]), .regulator_hot(cond[13]), .mgmt_interrupt_timeout(cond[14]),
    .dimm_err_threshold(cond[15]), .noncrit_temp(cond[16]), .noncrit_voltage(cond[17]),
    .noncrit_fan(cond[18]), .psu_predictive_fail(cond[19]), .channel_err_threshold(cond[20]),
    .mem_unusable(cond[21]), .multi_dimm_installed(cond[22]), .system_ready(cond[23]),
    .code_wr_en(code_wr_en), .code_wr_data(code_wr_data), .led_amber(led_amber),
    .led_green(led_green), .post_indicator(post_indicator));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // lit cycles of each colour over one full blink period: 8 steady, 4 blinking, 0 dark
  task automatic run(input logic [23:0] c, input logic [7:0] ea, input logic [7:0] eg);
    logic [7:0] na;
    logic [7:0] ng;
    logic [7:0] nx;
    na = 8'h00;
    ng = 8'h00;
    nx = 8'h00;
    sldiag_host_model_inst.set_cond(c);
    repeat (3) @(posedge clk);
    repeat (8) begin
      @(posedge clk) #1;
      na += {7'h00, led_amber === 1'b1};
      ng += {7'h00, led_green === 1'b1};
      // unknown levels counted apart so a dark expectation cannot pass on x
      nx += {7'h00, $isunknown({led_amber, led_green})};
    end
    check("amber lit cycles", na, ea);
    check("green lit cycles", ng, eg);
    check("unknown led cycles", nx, 8'h00);
  endtask
  // hang guard well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    check("post after reset", post_indicator, CODE_RST);
    run(24'h000000, 8'h00, 8'h00);
    run(24'h000001, 8'h00, 8'h00);
    run(BASE, 8'h00, 8'h08);
    for (int i = 1; i <= 5; i++) run(BASE | (24'h1 << i), 8'h08, 8'h00);
    run(24'h000002, 8'h08, 8'h00);
    run(BASE | 24'h0000c0, 8'h08, 8'h00);
    run(BASE | 24'h000080, 8'h00, 8'h08);
    run(BASE | 24'h0001c0, 8'h00, 8'h04);
    for (int i = 9; i <= 15; i++) run(BASE | (24'h1 << i), 8'h04, 8'h00);
    for (int i = 16; i <= 20; i++) run(BASE | (24'h1 << i), 8'h00, 8'h04);
    run(BASE | 24'h600000, 8'h00, 8'h04);
    run(BASE | 24'h200000, 8'h00, 8'h08);
    run(BASE | 24'h1f0210, 8'h08, 8'h00);
    run(BASE | 24'h1f0200, 8'h04, 8'h00);
    run(24'h000000, 8'h00, 8'h00);
    sldiag_host_model_inst.write_code(8'h80);
    sldiag_host_model_inst.idle();
    @(posedge clk) #1;
    check("top bit indicator", {7'h00, post_indicator[7]}, 8'h01);
    check("bottom bit indicator", {7'h00, post_indicator[0]}, 8'h00);
    sldiag_host_model_inst.write_code(8'h3c);
    sldiag_host_model_inst.write_code(8'hc3);
    check("first of pair", post_indicator, 8'h3c);
    sldiag_host_model_inst.idle();
    check("second of pair", post_indicator, 8'hc3);
    repeat (20) @(posedge clk);
    #1 check("held code", post_indicator, 8'hc3);
    end_of_test();
  end
endmodule
